// ### rtl/rxb1_id_status.sv
// Second receive buffer: filter hit, identifier bytes, full flag, interrupt.
// Assumes a synchronous engine strobe and the plain register port.
//
// The register addresses and the plain strobed port were decided locally.
`timescale 1ns/100ps
`include "rxb1_cfg.svh"
module rxb1_id_status (
    input wire logic ref_clk, // 50 MHz system clock
    input wire logic reset, // Synchronous, active high
    input wire rxb1_pkg::frame_t frame, // Accepted frame from the engine
    input wire logic frame_valid, // One-cycle strobe with frame
    input wire logic first_full, // First buffer full flag
    input wire rxb1_pkg::bus_req_t bus, // Register access request
    output logic [7:0] rdata, // Read data, cycle after read strobe
    output logic irq, // Level interrupt
    output logic buffer_full_flag // Buffer holds a message
);
    ////////////////////////////////////////////////////////////////////
    logic full_reg, full_next;
    logic ext_reg, ext_next;
    logic rtr_reg, rtr_next;
    logic [28:0] id_reg, id_next;
    logic [`ENH_HIT_W-1:0] hit_reg, hit_next;
    logic dben_reg, dben_next;
    logic enh_reg, enh_next;
    logic [`IRQ_W-1:0] stat_reg, stat_next;
    logic [`IRQ_W-1:0] mask_reg, mask_next;
    logic [7:0] rdata_reg, rdata_next;
    logic irq_reg, irq_next;
    logic take;
    logic drop;
    logic [7:0] ctrl_byte;
    logic [7:0] sid_high;
    logic [7:0] sid_low;
    logic [7:0] eid_high;

    function automatic logic hit_addr(input rxb1_pkg::bus_req_t b, input logic [`ADDR_W-1:0] a);
        hit_addr = (b.addr == a);
    endfunction : hit_addr

    ////////////////////////////////////////////////////////////////////
    // Frame acceptance
    always_comb begin
        logic wants;
        wants = frame_valid && (!frame.to_first || (dben_reg && first_full));
        take = wants && !full_reg;
        drop = wants && full_reg;
    end

    always_comb begin
        sid_high = frame_sid_high(ext_reg, id_reg);
    end

    function automatic logic [7:0] frame_sid_high(input logic e, input logic [28:0] i);
        frame_sid_high = e ? i[28:21] : i[10:3];
    endfunction : frame_sid_high

    always_comb begin
        sid_low = `ZERO8;
        sid_low[7:5] = ext_reg ? id_reg[20:18] : id_reg[2:0];
        sid_low[`BIT_SUB_REMOTE] = ext_reg ? 1'b0 : rtr_reg;
        sid_low[`BIT_EXT_FLAG] = ext_reg;
        // Bit 2 stays zero via the default above
        sid_low[1:0] = ext_reg ? id_reg[17:16] : `ZERO2;
        eid_high = ext_reg ? id_reg[15:8] : `ZERO8;
    end

    always_comb begin
        ctrl_byte = `ZERO8;
        if (enh_reg) begin
            ctrl_byte[`BIT_FULL_ENH] = full_reg;
            ctrl_byte[`BIT_RTR_ENH] = rtr_reg;
            ctrl_byte[`ENH_HIT_W-1:0] = hit_reg;
        end else begin
            ctrl_byte[`BIT_FULL] = full_reg;
            ctrl_byte[`BIT_RTR] = rtr_reg;
            ctrl_byte[`LEGACY_HIT_W-1:0] = hit_reg[`LEGACY_HIT_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        full_next = full_reg;
        ext_next = ext_reg;
        rtr_next = rtr_reg;
        id_next = id_reg;
        hit_next = hit_reg;
        dben_next = dben_reg;
        enh_next = enh_reg;
        stat_next = stat_reg;
        mask_next = mask_reg;
        rdata_next = `ZERO8;
        if (bus.wr && hit_addr(bus, `OFF_BUF_CTRL) && !bus.wdata[`BIT_FULL]) begin
            full_next = 1'b0;
        end
        if (bus.wr && hit_addr(bus, `OFF_MODE)) begin
            dben_next = bus.wdata[`BIT_DBEN];
            enh_next = bus.wdata[`BIT_ENH];
        end
        if (bus.wr && hit_addr(bus, `OFF_IRQ_MASK)) begin
            mask_next = bus.wdata[`IRQ_W-1:0];
        end
        // Identifier bytes have no write path
        if (bus.rd) begin
            case (bus.addr)
                `OFF_BUF_CTRL: rdata_next = ctrl_byte;
                `OFF_STD_ID_HIGH: rdata_next = sid_high;
                `OFF_STD_ID_LOW: rdata_next = sid_low;
                `OFF_EXT_ID_HIGH: rdata_next = eid_high;
                `OFF_ENH_HIT: rdata_next = {3'h0, hit_reg};
                `OFF_IRQ_STATUS: rdata_next = {6'h00, stat_reg};
                `OFF_IRQ_MASK: rdata_next = {6'h00, mask_reg};
                `OFF_MODE: rdata_next = {6'h00, enh_reg, dben_reg};
                default: rdata_next = `ZERO8;
            endcase
            if (hit_addr(bus, `OFF_IRQ_STATUS)) begin
                stat_next = '0;
            end
        end
        if (take) begin
            full_next = 1'b1;
            ext_next = frame.ext;
            rtr_next = frame.rtr;
            id_next = frame.id;
            hit_next = frame.hit;
        end
        // Set wins over read clear
        if (take) begin
            stat_next[`IRQ_LOAD] = 1'b1;
        end
        if (drop) begin
            stat_next[`IRQ_DROP] = 1'b1;
        end
        irq_next = |(stat_next & mask_next);
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            full_reg <= 1'b0;
            ext_reg <= 1'b0;
            rtr_reg <= 1'b0;
            id_reg <= 29'h0000_0000;
            hit_reg <= 5'h00;
            dben_reg <= 1'b0;
            enh_reg <= 1'b0;
            stat_reg <= 2'h0;
            mask_reg <= 2'h0;
            rdata_reg <= `ZERO8;
            irq_reg <= 1'b0;
        end else begin
            full_reg <= full_next;
            ext_reg <= ext_next;
            rtr_reg <= rtr_next;
            id_reg <= id_next;
            hit_reg <= hit_next;
            dben_reg <= dben_next;
            enh_reg <= enh_next;
            stat_reg <= stat_next;
            mask_reg <= mask_next;
            rdata_reg <= rdata_next;
            irq_reg <= irq_next;
        end
    end

    assign rdata = rdata_reg;
    assign irq = irq_reg;
    assign buffer_full_flag = full_reg;
endmodule : rxb1_id_status

// ### rtl/rxb1_cfg.svh
// Constants for the second receive buffer status and identifier block.
// Assumes inclusion by the package and the design module only.
`ifndef RXB1_CFG_SVH
`define RXB1_CFG_SVH
`define ADDR_W 4
`define OFF_BUF_CTRL 4'h0
`define OFF_STD_ID_HIGH 4'h1
`define OFF_STD_ID_LOW 4'h2
`define OFF_EXT_ID_HIGH 4'h3
`define OFF_ENH_HIT 4'h4
`define OFF_IRQ_STATUS 4'h5
`define OFF_IRQ_MASK 4'h6
`define OFF_MODE 4'h7
`define BIT_FULL 7
`define BIT_RTR 3
`define BIT_FULL_ENH 7
`define BIT_RTR_ENH 5
`define BIT_SUB_REMOTE 4
`define BIT_EXT_FLAG 3
`define BIT_DBEN 0
`define BIT_ENH 1
`define IRQ_LOAD 0
`define IRQ_DROP 1
`define IRQ_W 2
`define LEGACY_HIT_W 3
`define ENH_HIT_W 5
`define ZERO8 8'h00
`define ZERO2 2'h0
`endif

// ### rtl/rxb1_pkg.sv
// Types shared by the receive buffer block and its bench.
// Assumes rxb1_cfg.svh defines the widths.
`include "rxb1_cfg.svh"
package rxb1_pkg;
    // One accepted frame as handed over by the protocol engine
    typedef struct packed {
        logic ext; // Extended identifier frame
        logic rtr; // Remote request frame
        logic [28:0] id; // Standard id in [10:0] or full extended id
        logic [`ENH_HIT_W-1:0] hit; // Accepting filter number
        logic to_first; // Frame targets the first buffer
    } frame_t;
    typedef struct packed {
        logic [`ADDR_W-1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } bus_req_t;
endpackage : rxb1_pkg

// ### tb/rxb1_engine_model.sv
// Protocol engine model offering accepted frames.
// Assumes the bench calls send after reset.
`timescale 1ns/100ps
module rxb1_engine_model (
    input wire logic ref_clk, // Clock
    output rxb1_pkg::frame_t frame, // Offered frame
    output logic frame_valid, // Offer strobe
    output logic first_full // First buffer full
);
    initial begin
        frame = '0;
        frame_valid = 1'b0;
        first_full = 1'b0;
    end
    task automatic send(input rxb1_pkg::frame_t f, input logic ff);
        @(posedge ref_clk);
        frame <= f;
        frame_valid <= 1'b1;
        first_full <= ff;
        @(posedge ref_clk);
        frame <= ~f;
        frame_valid <= 1'b0;
        #1;
    endtask : send
endmodule : rxb1_engine_model

// ### tb/rxb1_id_status_assertions.sv
// Port checker for the receive buffer block.
// Assumes binding onto the design top.
`timescale 1ns/100ps
module rxb1_id_status_assertions (
    input wire logic ref_clk, // Clock
    input wire logic reset, // Reset
    input wire rxb1_pkg::frame_t frame, // Frame
    input wire logic frame_valid, // Strobe
    input wire logic first_full, // First full
    input wire rxb1_pkg::bus_req_t bus, // Bus
    input wire logic [7:0] rdata, // Read data
    input wire logic irq, // Interrupt
    input wire logic buffer_full_flag // Full
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    property p_ld; frame_valid && !frame.to_first && !buffer_full_flag |=> buffer_full_flag; endproperty
    a_ld: assert property (p_ld) else $error("no load");
    property p_hd; buffer_full_flag && !(bus.wr && bus.addr == 4'h0) |=> buffer_full_flag; endproperty
    a_hd: assert property (p_hd) else $error("full lost");
    property p_cl; bus.wr && bus.addr == 4'h0 && !bus.wdata[7] && !frame_valid |=> !buffer_full_flag; endproperty
    a_cl: assert property (p_cl) else $error("no clear");
    property p_nf;
        frame_valid && frame.to_first && !first_full && !(bus.wr && bus.addr == 4'h0)
            |=> $stable(buffer_full_flag);
    endproperty
    a_nf: assert property (p_nf) else $error("stray load");
    property p_b2; $past(bus.rd) && $past(bus.addr) == 4'h2 |-> !rdata[2]; endproperty
    a_b2: assert property (p_b2) else $error("bit2 set");
    property p_sr; $past(bus.rd) && $past(bus.addr) == 4'h2 && rdata[3] |-> !rdata[4]; endproperty
    a_sr: assert property (p_sr) else $error("substitute remote set");
    property p_rs; $rose(buffer_full_flag) |-> $past(frame_valid); endproperty
    a_rs: assert property (p_rs) else $error("full cause");
    property p_iq; $rose(irq) |-> $past(frame_valid) || $past(frame_valid, 2) || $past(bus.wr); endproperty
    a_iq: assert property (p_iq) else $error("irq cause");
endmodule : rxb1_id_status_assertions
bind rxb1_id_status rxb1_id_status_assertions chk (.ref_clk(ref_clk), .reset(reset),
    .frame(frame), .frame_valid(frame_valid), .first_full(first_full), .bus(bus),
    .rdata(rdata), .irq(irq), .buffer_full_flag(buffer_full_flag));

// ### tb/rxb1_id_status_tb.sv
// Bench for the receive buffer block.
// Assumes engine model and checker are compiled.
`timescale 1ns/100ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin fails++; $display("[ERR] %0t mismatch got %h exp %h", $time, a, e); end end
module rxb1_id_status_tb;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    rxb1_pkg::bus_req_t bus = '0;
    rxb1_pkg::frame_t frame, f;
    logic frame_valid, first_full, irq, buffer_full_flag;
    logic [7:0] rdata;
    int fails = 0;
    int checked = 0;
    rxb1_engine_model eng (.ref_clk(ref_clk), .frame(frame), .frame_valid(frame_valid),
        .first_full(first_full));
    rxb1_id_status dut (.ref_clk(ref_clk), .reset(reset), .frame(frame), .frame_valid(frame_valid),
        .first_full(first_full), .bus(bus), .rdata(rdata), .irq(irq),
        .buffer_full_flag(buffer_full_flag));
    initial forever #10 ref_clk = ~ref_clk;
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge ref_clk);
        bus.wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        bus <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge ref_clk);
        bus.rd <= 1'b0;
        #1;
        `CHK(rdata, e)
    endtask : rd
    ////////////////////////////////////////////////////////////////
    task automatic t_std;
        wr(4'h6, 8'h03);
        f = '{1'b0, 1'b1, 29'h0000_05A5, 5'h05, 1'b0};
        eng.send(f, 1'b0);
        `CHK(irq, 1'b1)
        rd(4'h1, f.id[10:3]);
        rd(4'h2, {f.id[2:0], f.rtr, 4'h0});
        rd(4'h3, 8'h00);
        rd(4'h0, {4'h8, f.rtr, f.hit[2:0]});
        rd(4'h5, 8'h01);
    endtask : t_std
    task automatic t_ext;
        f = '{1'b1, 1'b0, 29'h1B5E_A3C7, 5'h13, 1'b0};
        eng.send(f, 1'b0);
        wr(4'h1, 8'hFF);
        rd(4'h1, 8'hB4);
        rd(4'h5, 8'h02);
        wr(4'h0, 8'h00);
        wr(4'h7, 8'h02);
        eng.send(f, 1'b0);
        rd(4'h1, f.id[28:21]);
        rd(4'h2, {f.id[20:18], 3'b010, f.id[17:16]});
        rd(4'h3, f.id[15:8]);
        rd(4'h4, {3'b000, f.hit});
        rd(4'h0, {2'b10, f.rtr, f.hit});
    endtask : t_ext
    task automatic t_ovf;
        wr(4'h0, 8'h00);
        wr(4'h7, 8'h01);
        f = '{1'b0, 1'b0, 29'h0000_0123, 5'h01, 1'b1};
        eng.send(f, 1'b0);
        `CHK(buffer_full_flag, 1'b0)
        eng.send(f, 1'b1);
        `CHK(buffer_full_flag, 1'b1)
        rd(4'h0, 8'h81);
    endtask : t_ovf
    task automatic tally_and_finish;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (3000) @(posedge ref_clk);
        fails++;
        tally_and_finish();
    end
    initial begin
        repeat (5) @(posedge ref_clk);
        reset <= 1'b0;
        t_std();
        t_ext();
        t_ovf();
        tally_and_finish();
    end
endmodule : rxb1_id_status_tb
